// [hdl/slc_sleep_controller.sv]
// sleep mode sequencer with axi4-lite control registers
// Notes on behaviour
// - without enabled interrupt, only reset or debug break wakes
// - only sleep instruction enters sleep
// - idle stops cpu clock, peripherals run
// - standby gating follows run-in-standby bits
// - standby wakes on listed sources only
// - adc may run autonomously in standby
// - power-down keeps only watchdog and periodic timer
// - power-down wakes on pin change, address match
// - resume six cycles after clock stable
// - idle keeps main oscillator, no startup wait
// - power-down keeps only low-power oscillators
// - brownout fuse 0x3 waits for brownout ready
// - mode field 2:1 selects idle/standby/power-down
// - debug break wakes to active
// - handler runs, then instruction after sleep
// - any reset returns to active
`include "slc_map.svh"
module slc_sleep_controller #(
	parameter int WAKE_CYCLES = `SLC_WAKE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_instr,
	input wire logic debug_break,
	input wire logic [1:0] brownout_config_fuse,
	input wire logic brownout_ready,
	input wire logic main_clk_stable,
	input wire logic irq_pin,
	input wire logic irq_twi_addr,
	input wire logic irq_uart_sof,
	input wire logic irq_rtc,
	input wire logic irq_pit,
	input wire logic irq_adc_window,
	input wire logic irq_capture_timer,
	input wire logic irq_other,
	output logic cpu_clk_en,
	output logic per_clk_en,
	output logic rtc_clk_en,
	output logic adc_clk_en,
	output logic uart_clk_en,
	output logic pit_clk_en,
	output logic wdt_clk_en,
	output logic main_osc_en,
	output logic ulp_osc_en,
	output logic wake_irq_taken,
	output logic slc_asleep
);
	import slc_pkg::*;
	initial begin
		if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin
			$error("wake cycle count out of range");
		end
	end

	// pins and other-domain inputs pass two flip-flops
	localparam int NI = 13;
	logic [NI-1:0] raw_in, syn_in;
	assign raw_in = {debug_break, brownout_ready, main_clk_stable,
		irq_other, irq_capture_timer, irq_adc_window, irq_pit, irq_rtc,
		irq_uart_sof, irq_twi_addr, irq_pin, brownout_config_fuse};
	slc_sync #(.W(NI)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(raw_in),
		.q(syn_in)
	);
	logic dbg_s, bodrdy_s, clkok_s;
	logic [7:0] irq_s;
	logic [1:0] fuse_s;
	assign dbg_s = syn_in[12];
	assign bodrdy_s = syn_in[11];
	assign clkok_s = syn_in[10];
	assign irq_s = syn_in[9:2];
	assign fuse_s = syn_in[1:0];

	// register state
	logic [2:0] ctrl_q, ctrl_d;
	logic [`SLC_NUM_RUN_IN_STANDBY-1:0] rs_q, rs_d;
	logic [7:0] irqen_q, irqen_d;
	slc_state_e st_q, st_d;
	slc_mode_e mode_q, mode_d;
	logic asleep_q, asleep_d;

	// axi channel state
	logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d;
	logic arr_q, arr_d, rv_q, rv_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0] rr_q, rr_d;

	// address decode used for reads and writes
	function automatic logic addr_ok(input logic [7:0] a);
		if (a == `SLC_CTRL_OFFSET) begin
			return 1'b1;
		end else if (a == `SLC_STATUS_OFFSET) begin
			return 1'b1;
		end else if (a == `SLC_STBY_OFFSET) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// status word: state, mode in force, pending irq levels
	logic [31:0] status_w;
	assign status_w = {16'h0000, irq_s, st_q, mode_q, 2'h0};

	// wake sources allowed per mode, masked by enables
	logic [7:0] allow;
	logic wake_ok;
	always_comb begin
		allow = 8'h00;
		case (mode_q)
			SLC_MODE_IDLE: begin
				allow = 8'hFF;
			end
			SLC_MODE_STANDBY: begin
				allow[0] = 1'b1;
				allow[1] = 1'b1;
				allow[2] = rs_q[SLC_RS_UART];
				allow[3] = rs_q[SLC_RS_RTC];
				allow[4] = 1'b1;
				allow[5] = rs_q[SLC_RS_ADC];
				allow[6] = 1'b1;
			end
			SLC_MODE_POWER_DOWN_MODE: begin
				allow[0] = 1'b1;
				allow[1] = 1'b1;
			end
			default: begin
				allow = 8'h00;
			end
		endcase
	end
	// without any enabled source nothing wakes except reset or debug break
	assign wake_ok = |(irq_s & irqen_q & allow);

	// wake counter instance
	slc_wake_if wk ();
	logic start_q, start_d;
	assign wk.start = start_q;
	assign wk.bod_wait = (fuse_s == `SLC_BOD_WAIT_CODE);
	assign wk.bod_ready = bodrdy_s;
	slc_wake_counter #(.WAKE_CYCLES(WAKE_CYCLES)) u_cnt (
		.aclk(aclk),
		.aresetn(aresetn),
		.wk(wk)
	);

	// sleep sequencer and register writes
	logic aw_do, irq_tk_q, irq_tk_d;
	assign aw_do = awr_q && wr_q && !bv_q;
	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		ctrl_d = ctrl_q;
		rs_d = rs_q;
		irqen_d = irqen_q;
		start_d = 1'b0;
		irq_tk_d = 1'b0;
		if (aw_do && ws_q[0]) begin
			if (awa_q == `SLC_CTRL_OFFSET) begin
				ctrl_d = wd_q[2:0];
			end else if (awa_q == `SLC_STBY_OFFSET) begin
				rs_d = wd_q[`SLC_NUM_RUN_IN_STANDBY-1:0];
			end
		end
		if (aw_do && ws_q[1] && awa_q == `SLC_STBY_OFFSET) begin
			irqen_d = wd_q[15:8];
		end
		case (st_q)
			SLC_ST_ACTIVE: begin
				// register writes alone never stop the cpu
				if (sleep_instr && ctrl_q[`SLC_SEN_BIT] &&
					ctrl_q[`SLC_MODE_HI:`SLC_MODE_LO] != 2'h3) begin
					st_d = SLC_ST_SLEEP;
					mode_d = slc_mode_e'(ctrl_q[`SLC_MODE_HI:`SLC_MODE_LO]);
				end
			end
			SLC_ST_SLEEP: begin
				if (wake_ok || dbg_s) begin
					st_d = SLC_ST_CLKWAIT;
					irq_tk_d = wake_ok;
				end
			end
			SLC_ST_CLKWAIT: begin
				// idle keeps the oscillator so stable is immediate
				if (clkok_s || mode_q == SLC_MODE_IDLE) begin
					st_d = SLC_ST_COUNT;
					start_d = 1'b1;
				end
			end
			SLC_ST_COUNT: begin
				if (wk.done) begin
					st_d = SLC_ST_ACTIVE;
				end
			end
			default: begin
				st_d = SLC_ST_ACTIVE;
			end
		endcase
		// flop copy of the next state keeps the status pin glitch free
		asleep_d = (st_d != SLC_ST_ACTIVE);
	end

	// clock and peripheral gating per state and mode
	logic [8:0] gate_d, gate_q;
	always_comb begin
		gate_d = 9'h1FF;
		if (st_q != SLC_ST_ACTIVE) begin
			gate_d[0] = 1'b0;
			case (mode_q)
				SLC_MODE_STANDBY: begin
					gate_d[1] = rs_q[SLC_RS_PER];
					gate_d[2] = rs_q[SLC_RS_RTC];
					gate_d[3] = rs_q[SLC_RS_ADC];
					gate_d[4] = rs_q[SLC_RS_UART];
					gate_d[7] = rs_q[SLC_RS_OSC];
				end
				SLC_MODE_POWER_DOWN_MODE: begin
					gate_d[4:1] = 4'h0;
					gate_d[7] = 1'b0;
				end
				default: begin
					gate_d[0] = 1'b0;
				end
			endcase
			// oscillator back on once wake has begun
			if (st_q != SLC_ST_SLEEP) begin
				gate_d[7] = 1'b1;
			end
		end
	end

	// axi4-lite slave, one write and one read at a time
	always_comb begin
		awr_d = awr_q;
		wr_d = wr_q;
		bv_d = bv_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		br_d = br_q;
		arr_d = arr_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_awvalid && !awr_q && !bv_q) begin
			awr_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wr_q && !bv_q) begin
			wr_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (aw_do) begin
			awr_d = 1'b0;
			wr_d = 1'b0;
			bv_d = 1'b1;
			br_d = addr_ok(awa_q) ? 2'h0 : 2'h2;
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		arr_d = s_axi_arvalid && !arr_q && !rv_q;
		if (arr_q) begin
			rv_d = 1'b1;
			rr_d = addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
			if (s_axi_araddr == `SLC_CTRL_OFFSET) begin
				rd_d = {29'h0, ctrl_q};
			end else if (s_axi_araddr == `SLC_STATUS_OFFSET) begin
				rd_d = status_w;
			end else if (s_axi_araddr == `SLC_STBY_OFFSET) begin
				rd_d = {16'h0000, irqen_q, 3'h0, rs_q};
			end else begin
				rd_d = 32'h0000_0000;
			end
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
	end

	// every register; reset returns to active from any mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= SLC_ST_ACTIVE;
			asleep_q <= 1'b0;
			mode_q <= SLC_MODE_IDLE;
			ctrl_q <= 3'h0;
			rs_q <= '0;
			irqen_q <= 8'h00;
			start_q <= 1'b0;
			irq_tk_q <= 1'b0;
			gate_q <= 9'h1FF;
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			bv_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			br_q <= 2'h0;
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			rr_q <= 2'h0;
		end else begin
			st_q <= st_d;
			asleep_q <= asleep_d;
			mode_q <= mode_d;
			ctrl_q <= ctrl_d;
			rs_q <= rs_d;
			irqen_q <= irqen_d;
			start_q <= start_d;
			irq_tk_q <= irq_tk_d;
			gate_q <= gate_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
			bv_q <= bv_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			br_q <= br_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready = wr_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;
	assign cpu_clk_en = gate_q[0];
	assign per_clk_en = gate_q[1];
	assign rtc_clk_en = gate_q[2];
	assign adc_clk_en = gate_q[3];
	assign uart_clk_en = gate_q[4];
	assign pit_clk_en = gate_q[5];
	assign wdt_clk_en = gate_q[6];
	assign main_osc_en = gate_q[7];
	assign ulp_osc_en = gate_q[8];
	assign wake_irq_taken = irq_tk_q;
	assign slc_asleep = asleep_q;
endmodule

// [common/slc_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
`define SLC_CTRL_OFFSET 8'h00
`define SLC_STATUS_OFFSET 8'h04
`define SLC_STBY_OFFSET 8'h08
`define SLC_CTRL_RESET 8'h00
`define SLC_SEN_BIT 0
`define SLC_MODE_LO 1
`define SLC_MODE_HI 2
`define SLC_BOD_WAIT_CODE 2'h3
`define SLC_WAKE_CYCLES 6
`define SLC_NUM_RUN_IN_STANDBY 5
`endif

// [common/slc_pkg.sv]
// types shared by the sleep controller files
package slc_pkg;
	typedef enum logic [1:0] {
		SLC_MODE_IDLE = 2'h0,
		SLC_MODE_STANDBY = 2'h1,
		SLC_MODE_POWER_DOWN_MODE = 2'h2,
		SLC_MODE_RSVD = 2'h3
	} slc_mode_e;
	typedef enum logic [3:0] {
		SLC_ST_ACTIVE = 4'b0001,
		SLC_ST_SLEEP = 4'b0010,
		SLC_ST_CLKWAIT = 4'b0100,
		SLC_ST_COUNT = 4'b1000
	} slc_state_e;
	// run-in-standby bit positions
	typedef enum int {
		SLC_RS_RTC = 0,
		SLC_RS_ADC = 1,
		SLC_RS_UART = 2,
		SLC_RS_OSC = 3,
		SLC_RS_PER = 4
	} slc_rs_e;
endpackage

// [common/slc_wake_if.sv]
// wake counter handshake between the sequencer and its delay counter
interface slc_wake_if;
	logic start;
	logic bod_wait;
	logic bod_ready;
	logic done;
	modport seq (output start, output bod_wait, output bod_ready, input done);
	modport cnt (input start, input bod_wait, input bod_ready, output done);
endinterface

// [hdl/slc_wake_counter.sv]
// wake delay counter on the ungated bus clock aclk
`include "slc_map.svh"
module slc_wake_counter #(
	parameter int WAKE_CYCLES = `SLC_WAKE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	slc_wake_if.cnt wk
);
	import slc_pkg::*;
	initial begin
		if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin
			$error("wake cycle count out of range");
		end
	end
	logic [7:0] cnt_q, cnt_d;
	logic run_q, run_d;
	logic done_q, done_d;
	// counting starts on start; done waits for brownout ready if asked
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (wk.start) begin
			cnt_d = 8'h00;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q < 8'(WAKE_CYCLES - 1)) begin
				cnt_d = cnt_q + 8'h01;
			end else if (!wk.bod_wait || wk.bod_ready) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end
	assign wk.done = done_q;
endmodule

// [hdl/slc_sync.sv]
// two flip-flop synchroniser for a bundle of levels
module slc_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	initial begin
		if (W < 1) begin
			$error("sync width must be positive");
		end
	end
	logic [W-1:0] s1_q, s2_q;
	// first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule

// [testbench/slc_sleep_monitor.sv]
// port assertions for the sleep controller
module slc_sleep_monitor #(
	parameter int WAKE_CYCLES = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sleep_instr,
	input wire logic debug_break,
	input wire logic [1:0] brownout_config_fuse,
	input wire logic brownout_ready,
	input wire logic irq_pin,
	input wire logic irq_twi_addr,
	input wire logic irq_uart_sof,
	input wire logic irq_rtc,
	input wire logic irq_pit,
	input wire logic irq_adc_window,
	input wire logic irq_capture_timer,
	input wire logic irq_other,
	input wire logic cpu_clk_en,
	input wire logic per_clk_en,
	input wire logic pit_clk_en,
	input wire logic wdt_clk_en,
	input wire logic slc_asleep
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] quiet_q;
	logic [4:0] quiet_d;
	logic calm;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// cycles with no wake cause at all, saturating
	always_comb begin
		calm = !debug_break && {irq_pin, irq_twi_addr, irq_uart_sof, irq_rtc,
			irq_pit, irq_adc_window, irq_capture_timer, irq_other} == 8'h00;
		quiet_d = !calm ? 5'h00 : (quiet_q == 5'h1F ? quiet_q : quiet_q + 5'h01);
	end
	always_ff @(posedge aclk) begin
		quiet_q <= !aresetn ? 5'h00 : quiet_d;
	end
	reset_state_a: assert property ($rose(aresetn) |-> !slc_asleep
		&& cpu_clk_en && per_clk_en) else $error("not active after reset");
	entry_cause_a: assert property ($rose(slc_asleep) |-> $past(sleep_instr))
		else $error("sleep without instruction");
	cpu_gate_a: assert property ($rose(slc_asleep) |=> !cpu_clk_en)
		else $error("cpu clock not stopped");
	timers_run_a: assert property (slc_asleep |-> wdt_clk_en && pit_clk_en)
		else $error("watchdog or periodic timer stopped");
	min_sleep_a: assert property ($rose(slc_asleep) |-> slc_asleep[*6])
		else $error("wake delay too short");
	bod_wait_a: assert property ($fell(slc_asleep)
		&& brownout_config_fuse == 2'h3 |-> $past(brownout_ready, 2))
		else $error("woke before brownout ready");
	debug_wake_a: assert property ($rose(debug_break) && slc_asleep
		|-> ##[1:60] !slc_asleep) else $error("debug break did not wake");
	no_cause_a: assert property (slc_asleep && quiet_q == 5'h1F |=> slc_asleep)
		else $error("woke with no cause");
endmodule
bind slc_sleep_controller slc_sleep_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_mon (.*);

// [testbench/slc_partner.sv]
// clock controller and brownout detector model
module slc_partner #(
	parameter int STARTUP = 20
) (
	input wire logic aclk,
	input wire logic main_osc_en,
	input wire logic bod_hold,
	output logic main_clk_stable,
	output logic brownout_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// stable only after STARTUP running cycles, so a stopped source costs time
	always @(posedge aclk) begin
		if (main_osc_en !== 1'b1) cnt <= 0;
		else if (cnt < STARTUP) cnt <= cnt + 1;
	end
	assign main_clk_stable = cnt >= STARTUP;
	// a slow detector keeps ready low, as a sagging supply would
	assign brownout_ready = !bod_hold;
endmodule

// [testbench/slc_sleep_controller_test.sv]
// self-checking bench for the sleep controller
module slc_sleep_controller_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] m; logic [7:0] rs, en, irq;
		logic wk, per, osc; int lo, hi;} slc_row_s;
	logic aclk, aresetn, sleep_instr, debug_break, bod_hold;
	logic brownout_ready, main_clk_stable;
	logic [7:0] s_axi_awaddr, s_axi_araddr, irqv;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, brownout_config_fuse, r, b;
	logic [2:0] g;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq_pin, irq_twi_addr, irq_uart_sof;
	logic irq_rtc, irq_pit, irq_adc_window, irq_capture_timer, irq_other;
	logic cpu_clk_en, per_clk_en, rtc_clk_en, adc_clk_en, uart_clk_en;
	logic pit_clk_en, wdt_clk_en, main_osc_en, ulp_osc_en;
	logic wake_irq_taken, slc_asleep;
	int err_total = 0, cmp_count = 0, wits = 0, w0, lat;
	slc_row_s rows [11];
	assign {irq_other, irq_capture_timer, irq_adc_window, irq_pit, irq_rtc,
		irq_uart_sof, irq_twi_addr, irq_pin} = irqv;
	slc_sleep_controller u_slc_sleep_controller (.*);
	slc_partner u_slc_partner (.aclk(aclk), .main_osc_en(main_osc_en),
		.bod_hold(bod_hold), .main_clk_stable(main_clk_stable),
		.brownout_ready(brownout_ready));
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	// interrupt wake pulses counted for the handler check
	always @(posedge aclk) if (wake_irq_taken === 1'b1) wits++;
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'h3};
		s_axi_bready <= 1;
		// each channel drops its valid at its own handshake edge
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		b = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// sleep instruction one cycle, then let the gates settle
	task nap(input logic [1:0] m);
		wr(8'h00, {29'h0, m, 1'b1});
		@(posedge aclk) sleep_instr <= 1;
		@(posedge aclk) sleep_instr <= 0;
		repeat (3) @(posedge aclk);
	endtask
	task wt();
		for (lat = 0; lat < 80 && slc_asleep === 1'b1; lat++) @(posedge aclk);
	endtask
	task wrap_up();
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		{aresetn, sleep_instr, debug_break, bod_hold, irqv} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{s_axi_wstrb, brownout_config_fuse} = 6'h3C;
		// mode, run bits, enables, irq, wakes, periph, osc, latency window
		rows = '{'{0, 0, 8'hFF, 8'h80, 1, 1, 1, 6, 14},
			'{1, 0, 8'hFF, 8'h01, 1, 0, 0, 26, 60}, '{1, 0, 8'hFF, 8'h80, 0, 0, 0, 0, 0},
			'{1, 4, 8'hFF, 8'h04, 1, 0, 0, 26, 60}, '{1, 0, 8'hFF, 8'h04, 0, 0, 0, 0, 0},
			'{1, 8'h18, 8'hFF, 8'h40, 1, 1, 1, 6, 14}, '{1, 1, 8'hFF, 8'h08, 1, 0, 0, 26, 60},
			'{2, 0, 8'hFF, 8'h01, 1, 0, 0, 26, 60}, '{2, 0, 8'hFF, 8'h08, 0, 0, 0, 0, 0},
			'{2, 0, 8'hFF, 8'h02, 1, 0, 0, 26, 60}, '{0, 0, 8'h00, 8'h01, 0, 1, 1, 0, 0}};
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (30) @(posedge aclk);
		foreach (rows[i]) begin
			wr(8'h08, {16'h0, rows[i].en, rows[i].rs});
			nap(rows[i].m);
			w0 = wits;
			chk({slc_asleep, cpu_clk_en, per_clk_en}, {2'h2, rows[i].per});
			chk(main_osc_en, rows[i].osc);
			g = rows[i].m == 2'h1 ? {rows[i].rs[0], rows[i].rs[1], rows[i].rs[2]}
				: {3{rows[i].m == 2'h0}};
			chk({rtc_clk_en, adc_clk_en, uart_clk_en}, g);
			chk({pit_clk_en, wdt_clk_en, ulp_osc_en}, 3'h7);
			irqv <= rows[i].irq;
			wt();
			chk(!slc_asleep, rows[i].wk);
			if (rows[i].wk) chk(lat >= rows[i].lo && lat <= rows[i].hi, 1);
			debug_break <= 1;
			wt();
			chk(slc_asleep, 0);
			chk(wits != w0, rows[i].wk);
			{debug_break, irqv} <= 0;
			repeat (30) @(posedge aclk);
		end
		rd(8'h00);
		chk(d, 32'h1);
		chk(r, 2'h0);
		rd(8'hFC);
		chk(d, 32'h0);
		chk(r, 2'h2);
		wr(8'hFC, 32'h0);
		chk(b, 2'h2);
		wr(8'h00, 32'hFF);
		chk(b, 2'h0);
		rd(8'h00);
		chk(d, 32'h7);
		nap(2'h3);
		chk(slc_asleep, 0);
		wr(8'h08, 32'hFF00);
		wr(8'h00, 32'h4);
		@(posedge aclk) sleep_instr <= 1;
		@(posedge aclk) sleep_instr <= 0;
		repeat (3) @(posedge aclk);
		chk(slc_asleep, 0);
		{brownout_config_fuse, bod_hold} <= 3'h7;
		nap(2'h0);
		irqv <= 1;
		repeat (30) @(posedge aclk);
		chk(slc_asleep, 1);
		bod_hold <= 0;
		wt();
		chk(slc_asleep, 0);
		{brownout_config_fuse, irqv} <= 0;
		repeat (5) @(posedge aclk);
		// no source enabled: pending or quiet irqs never end sleep, reset does
		wr(8'h08, 32'h0);
		nap(2'h0);
		irqv <= 8'hFF;
		repeat (40) @(posedge aclk);
		chk(slc_asleep, 1);
		irqv <= 8'h00;
		repeat (40) @(posedge aclk);
		chk(slc_asleep, 1);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk({slc_asleep, cpu_clk_en, wdt_clk_en}, 3'h3);
		rd(8'h00);
		chk(d, 32'h0);
		wrap_up();
	end
endmodule
